// >>> eeprom_cmd_pkg.sv
// Shared constants and types of the serial EEPROM command and protection logic.
package eeprom_cmd_pkg;

  localparam logic [7:0] set_write_latch_cmd = 8'h06;
  localparam logic [7:0] clear_write_latch_cmd = 8'h04;
  localparam logic [7:0] status_read_cmd = 8'h05;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] array_read_cmd = 8'h03;
  localparam logic [7:0] array_write_cmd = 8'h02;
  localparam logic [7:0] id_page_read_cmd = 8'h83;
  localparam logic [7:0] id_page_write_cmd = 8'h82;

  localparam int sr_status_write_disable = 7;
  localparam int sr_block_protect_hi = 3;
  localparam int sr_block_protect_lo = 2;
  localparam int sr_write_enable_latch = 1;
  localparam int sr_write_in_progress = 0;

  localparam logic [11:0] quarter_base = 12'hC00;
  localparam logic [11:0] half_base = 12'h800;
  localparam logic [15:0] lock_select_addr = 16'h0400;
  localparam logic [15:0] id_addr_mask = 16'hFFE0;

  localparam logic [2:0] nv_reset = 3'h0;
  localparam logic [7:0] byte_reset = 8'h00;

  // Self-timed write cycle, in microseconds, and its length in system cycles.
  localparam int write_time_us = 5000;
  localparam int clk_mhz = 125;
  localparam int write_cycles = write_time_us * clk_mhz;

  typedef enum {
    st_opcode,
    st_addr,
    st_data,
    st_status_out,
    st_array_out,
    st_wait
  } cmd_state_t;

  // Synchronised serial pins.
  typedef struct packed {
    logic sel;
    logic sck;
    logic sdi;
    logic wp_n;
  } pins_t;

  // Write request handed to the self-timed write engine.
  typedef struct packed {
    logic status;
    logic array;
  } write_req_t;

endpackage : eeprom_cmd_pkg

// >>> write_timer.sv
// Self-timed internal write cycle counter.
`timescale 1ns/1ps
module write_timer
  import eeprom_cmd_pkg::*;
#(
  parameter int cycles = write_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [31:0] count_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 32'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        count_q <= 32'(cycles - 1);
      end else if (busy_q) begin
        if (count_q == 32'h0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - 32'h1;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : write_timer

// >>> spi_eeprom_command_protection.sv
// Command decoder, status byte and write protection of a serial EEPROM slave.
// What this block does
// - Writes execute only if the clock count while selected is a multiple of eight.
// - Select must rise after final bit's rising edge, before the next rising edge.
// - Final bit is eighth opcode or data bit; reads are exempt from the check.
// - Protect bits choose none, upper quarter, upper half or whole array.
// - Bytes travel most significant bit first; the opcode comes first.
// - Unknown opcode makes the device ignore input until deselected.
// - Opcodes 06h set latch, 04h clear latch, 05h read status.
// - Opcodes 01h status write, 03h array read, 02h array write.
// - 83h and 82h access the id page, or the lock state at address 0400h.
// - Array addresses are two bytes; only the low twelve bits count.
// - Only the set-latch command sets the latch, then the device waits.
// - Clear-latch command clears the latch, then the device waits.
// - Latch clears at reset, clear command and end of each write cycle.
// - Status read works anytime and repeats the status byte while selected.
// - Write-in-progress reads one during an internal write cycle, else zero.
// - With the latch clear, array and status writes are refused.
// - Protect bits are kept and changed only by an unprotected status write.
// - Disable bit set and protect pin low make status bits read-only.
// - Status byte: disable, three zeros, protect hi, protect lo, latch, in-progress.
// - Input sampled on rising clock edges, output changes on falling edges.
// - Status write starts a timed cycle; latch clears when it ends.
// - Status write leaves bits six to four and one to zero alone.
// - Array read during a write cycle is neither accepted nor executed.
`timescale 1ns/1ps
module spi_eeprom_command_protection
  import eeprom_cmd_pkg::*;
#(
  parameter int write_len = write_cycles,
  parameter bit id_page_present = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic wp_n,
  output logic sdo,
  output logic sdo_oe,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wstrobe,
  output logic mem_rstrobe,
  input wire logic [7:0] mem_rdata,
  output logic id_access,
  output logic lock_access,
  output logic array_write_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  pins_t meta_q;
  pins_t pins_q;
  logic sck_prev_q;
  logic sel_prev_q;
  logic rise;
  logic fall;
  logic sel_fall;
  logic sel_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '{sel: 1'b0, sck: 1'b0, sdi: 1'b0, wp_n: 1'b1};
      pins_q <= '{sel: 1'b0, sck: 1'b0, sdi: 1'b0, wp_n: 1'b1};
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= '{sel: !sel_n, sck: sck, sdi: sdi, wp_n: wp_n};
      pins_q <= meta_q;
      sck_prev_q <= pins_q.sck;
      sel_prev_q <= pins_q.sel;
    end
  end

  assign rise = pins_q.sel && pins_q.sck && !sck_prev_q;
  assign fall = pins_q.sel && !pins_q.sck && sck_prev_q;
  assign sel_fall = pins_q.sel && !sel_prev_q;
  assign sel_rise = !pins_q.sel && sel_prev_q;

  function automatic logic in_protected(input logic [1:0] bp, input logic [11:0] a);
    case (bp)
      2'b01: in_protected = (a >= quarter_base);
      2'b10: in_protected = (a >= half_base);
      2'b11: in_protected = 1'b1;
      default: in_protected = 1'b0;
    endcase
  endfunction : in_protected

  // Opcodes whose address phase is followed by a byte stream out of the array.
  function automatic logic is_read_op(input logic [7:0] op);
    is_read_op = (op == array_read_cmd) || (op == id_page_read_cmd);
  endfunction : is_read_op

  ////////////////////////////////////////////////////////////////////////////
  // Status bits.

  logic status_write_disable_q;
  logic [1:0] bp_q;
  logic wel_q;
  logic write_in_progress;
  logic wr_done;
  logic hw_protected;
  logic [7:0] status_byte;
  write_req_t req_q;
  logic [2:0] pend_nv_q;

  assign hw_protected = status_write_disable_q && !pins_q.wp_n;
  assign status_byte = {status_write_disable_q, 3'h0, bp_q, wel_q, write_in_progress};

  ////////////////////////////////////////////////////////////////////////////
  // Command shifter and decoder.

  cmd_state_t state_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [1:0] addr_bytes_q;
  logic [15:0] addr_q;
  logic [7:0] opcode_q;
  logic [7:0] out_q;
  logic sdo_q;
  logic byte_done_q;
  logic data_seen_q;
  logic [7:0] next_byte;

  assign next_byte = {shift_q[6:0], pins_q.sdi};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= st_opcode;
      shift_q <= byte_reset;
      bit_q <= 3'h0;
      addr_bytes_q <= 2'h0;
      addr_q <= 16'h0000;
      opcode_q <= byte_reset;
      out_q <= byte_reset;
      sdo_q <= 1'b0;
      byte_done_q <= 1'b0;
      data_seen_q <= 1'b0;
      mem_wdata <= byte_reset;
    end else if (ce) begin
      if (!pins_q.sel || sel_fall) begin
        state_q <= st_opcode;
        bit_q <= 3'h0;
        addr_bytes_q <= 2'h0;
        byte_done_q <= 1'b0;
        data_seen_q <= 1'b0;
      end else if (rise) begin
        shift_q <= next_byte;
        bit_q <= bit_q + 3'h1;
        // Any rising edge after a byte boundary breaks the deselect timing.
        byte_done_q <= (bit_q == 3'h7);
        if (bit_q == 3'h7) begin
          case (state_q)
            st_opcode: begin
              opcode_q <= next_byte;
              case (next_byte)
                set_write_latch_cmd: state_q <= st_wait;
                clear_write_latch_cmd: state_q <= st_wait;
                status_read_cmd: begin
                  state_q <= st_status_out;
                  out_q <= status_byte;
                end
                status_write_cmd: state_q <= st_data;
                array_read_cmd: state_q <= write_in_progress ? st_wait : st_addr;
                array_write_cmd: state_q <= st_addr;
                id_page_read_cmd: state_q <= id_page_present ? st_addr : st_wait;
                id_page_write_cmd: state_q <= id_page_present ? st_addr : st_wait;
                default: state_q <= st_wait;
              endcase
            end
            st_addr: begin
              addr_q <= {addr_q[7:0], next_byte};
              addr_bytes_q <= addr_bytes_q + 2'h1;
              if (addr_bytes_q == 2'h1) begin
                if (is_read_op(opcode_q)) begin
                  state_q <= st_array_out;
                end else begin
                  state_q <= st_data;
                end
              end
            end
            st_data: begin
              mem_wdata <= next_byte;
              data_seen_q <= 1'b1;
              if (data_seen_q && opcode_q != status_write_cmd) begin
                addr_q[4:0] <= addr_q[4:0] + 5'h1;
              end
            end
            st_status_out: out_q <= status_byte;
            st_array_out: begin
              addr_q[11:0] <= addr_q[11:0] + 12'h001;
            end
            default: state_q <= st_wait;
          endcase
        end
      end else if (fall) begin
        if (state_q == st_array_out && bit_q == 3'h0) begin
          // The address moved at the byte boundary, so the memory has answered by this edge.
          out_q <= mem_rdata;
          sdo_q <= mem_rdata[7];
        end else begin
          sdo_q <= out_q[3'h7 - bit_q];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution at deselect, latch and non-volatile bits.

  logic exec_ok;
  logic is_array_write;
  logic is_status_write;

  assign exec_ok = sel_rise && byte_done_q;
  assign is_array_write = exec_ok && state_q == st_data && data_seen_q &&
                          opcode_q != status_write_cmd;
  assign is_status_write = exec_ok && state_q == st_data && data_seen_q &&
                           opcode_q == status_write_cmd;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
      req_q <= '0;
      pend_nv_q <= nv_reset;
    end else if (ce) begin
      req_q <= '0;
      if (exec_ok && state_q == st_wait && opcode_q == set_write_latch_cmd && !write_in_progress) begin
        wel_q <= 1'b1;
      end else if (exec_ok && state_q == st_wait && opcode_q == clear_write_latch_cmd) begin
        wel_q <= 1'b0;
      end else if (wr_done) begin
        wel_q <= 1'b0;
      end
      if (is_status_write && wel_q && !hw_protected && !write_in_progress) begin
        req_q.status <= 1'b1;
        pend_nv_q <= {mem_wdata[sr_status_write_disable],
                      mem_wdata[sr_block_protect_hi], mem_wdata[sr_block_protect_lo]};
      end
      if (is_array_write && wel_q && !write_in_progress &&
          !(opcode_q == array_write_cmd && in_protected(bp_q, addr_q[11:0]))) begin
        req_q.array <= 1'b1;
      end
    end
  end

  // Protect bits are modelled by plain flip-flops; reset stands in for delivery state.
  logic status_cycle_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_write_disable_q <= nv_reset[2];
      bp_q <= nv_reset[1:0];
      status_cycle_q <= 1'b0;
    end else if (ce) begin
      if (req_q.status) begin
        status_cycle_q <= 1'b1;
      end else if (wr_done && status_cycle_q) begin
        status_cycle_q <= 1'b0;
        status_write_disable_q <= pend_nv_q[2];
        bp_q <= pend_nv_q[1:0];
      end else if (wr_done) begin
        status_cycle_q <= 1'b0;
      end
    end
  end

  write_timer #(
    .cycles(write_len)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(req_q.status || req_q.array),
    .busy(write_in_progress),
    .done(wr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_wstrobe <= 1'b0;
      mem_rstrobe <= 1'b0;
      array_write_start <= 1'b0;
    end else if (ce) begin
      mem_wstrobe <= rise && bit_q == 3'h7 && state_q == st_data &&
                     opcode_q != status_write_cmd;
      mem_rstrobe <= rise && bit_q == 3'h7 &&
                     (state_q == st_array_out ||
                      (state_q == st_addr && addr_bytes_q == 2'h1 && is_read_op(opcode_q)));
      array_write_start <= req_q.array;
    end
  end

  assign mem_addr = addr_q[11:0];
  assign id_access = opcode_q[7] && (addr_q & id_addr_mask) == 16'h0000;
  assign lock_access = opcode_q[7] && addr_q == lock_select_addr;
  assign sdo = sdo_q;
  assign sdo_oe = pins_q.sel && (state_q == st_status_out || state_q == st_array_out);

endmodule : spi_eeprom_command_protection

// >>> spi_eeprom_sva.sv
// Port-level checks of the serial EEPROM slave.
`timescale 1ns/1ps
module spi_eeprom_sva
  import eeprom_cmd_pkg::*;
#(
  parameter int write_len = write_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic mem_wstrobe,
  input wire logic mem_rstrobe,
  input wire logic array_write_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Six cycles cover the two-flop sync and edge detect on the pins.
  sequence idle_s;
    sel_n [*6];
  endsequence
  sequence sck_high_s;
    (sck && sdo_oe) [*6];
  endsequence
  chk_oe_idle: assert property (idle_s |-> !sdo_oe)
    else $error("sdo_oe while deselected");
  chk_sdo_edge: assert property (sck_high_s |-> $stable(sdo))
    else $error("sdo moved with sck high");
  chk_wstrobe_once: assert property (mem_wstrobe |=> !mem_wstrobe)
    else $error("write strobe too long");
  chk_rstrobe_once: assert property (mem_rstrobe |=> !mem_rstrobe)
    else $error("read strobe too long");
  chk_start_desel: assert property (array_write_start |-> sel_n)
    else $error("write began while selected");
  chk_start_gap: assert property (array_write_start |=> !array_write_start [*8])
    else $error("write began twice");
  chk_wstrobe_idle: assert property (idle_s |-> !mem_wstrobe)
    else $error("write strobe while deselected");
  chk_rstrobe_idle: assert property (idle_s |-> !mem_rstrobe)
    else $error("read strobe while deselected");
endmodule : spi_eeprom_sva
bind spi_eeprom_command_protection spi_eeprom_sva #(.write_len(write_len)) i_sva (
  .clk(clk), .rst(rst), .sel_n(sel_n), .sck(sck), .sdo(sdo), .sdo_oe(sdo_oe),
  .mem_wstrobe(mem_wstrobe), .mem_rstrobe(mem_rstrobe),
  .array_write_start(array_write_start));

// >>> spi_master_model.sv
// Bus master model driving the serial pins in mode 0, or in mode 3 after set_idle.
`timescale 1ns/1ps
module spi_master_model (
  output logic sel_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  // Clock level between frames: low for mode 0, high for mode 3.
  bit idle_hi = 1'b0;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic shift(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (idle_hi) sck = 1'b0;
      sdi = tx[i];
      #62.5 sck = 1'b1;
      rx = {rx[14:0], sdo};
      #62.5;
      if (!idle_hi) sck = 1'b0;
    end
  endtask : shift
  // Change the idle clock level only while deselected.
  task automatic set_idle(input bit hi);
    idle_hi = hi;
    sck = hi;
    #500;
  endtask : set_idle
  // Deselect after the last rising edge and before the next one would come.
  task automatic stop();
    #20 sel_n = 1'b1;
    sdi = ~sdi;
    #500;
  endtask : stop
endmodule : spi_master_model

// >>> spi_eeprom_command_protection_tb_top.sv
// Self-checking bench of the serial EEPROM command and protection logic.
`timescale 1ns/1ps
module spi_eeprom_command_protection_tb_top;
  import eeprom_cmd_pkg::*;
  localparam int wlen = 1000;
  localparam int wait_ns = wlen * 8 + 500;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic sel_n, sck, sdi, sdo, sdo_oe, mem_rstrobe, id_access, lock_access, array_write_start;
  logic mem_wstrobe;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [15:0] rx;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int starts = 0;
  int reads = 0;
  int wstrobes = 0;
  int n;
  logic [7:0] t_sr [8] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h00};
  logic [15:0] t_ad [8] = '{16'h0FFF, 16'h0BFF, 16'h0C00, 16'h07FF, 16'h0800, 16'hF7FF,
    16'h0000, 16'h0123};
  logic [7:0] t_ok = 8'h2B;
  always #4 clk = ~clk;
  spi_master_model i_m (.sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(sdo));
  spi_eeprom_command_protection #(.write_len(wlen), .id_page_present(1'b1)) i_dut (
    .clk(clk), .rst(rst), .ce(1'b1), .sel_n(sel_n), .sck(sck), .sdi(sdi), .wp_n(wp_n),
    .sdo(sdo), .sdo_oe(sdo_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wstrobe(mem_wstrobe), .mem_rstrobe(mem_rstrobe), .mem_rdata(8'hA5),
    .id_access(id_access),
    .lock_access(lock_access), .array_write_start(array_write_start));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op);
    i_m.shift(8, {8'h00, op}, rx);
    i_m.stop();
  endtask : cmd
  task automatic rd_st(input logic [7:0] exp);
    i_m.shift(8, {8'h00, status_read_cmd}, rx);
    i_m.shift(8, 16'h0000, rx);
    chk("sdo_oe", 16'h0001, {15'h0000, sdo_oe});
    i_m.stop();
    chk("status", {8'h00, exp}, rx);
    chk("sdo_oe_off", 16'h0000, {15'h0000, sdo_oe});
  endtask : rd_st
  // Status write without waiting, so callers can watch the running cycle.
  task automatic wr_st(input logic [7:0] v);
    cmd(set_write_latch_cmd);
    i_m.shift(16, {status_write_cmd, v}, rx);
    i_m.stop();
  endtask : wr_st
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (array_write_start) starts <= starts + 1;
    if (mem_rstrobe) reads <= reads + 1;
    if (mem_wstrobe) wstrobes <= wstrobes + 1;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    #300;
    rd_st(8'h00);
    cmd(set_write_latch_cmd);
    i_m.shift(8, {8'h00, status_read_cmd}, rx);
    i_m.shift(16, 16'h0000, rx);
    i_m.stop();
    chk("status_repeat", 16'h0202, rx);
    cmd(clear_write_latch_cmd);
    rd_st(8'h00);
    i_m.shift(16, {status_write_cmd, 8'h8C}, rx);
    i_m.stop();
    rd_st(8'h00);
    wr_st(8'hFC);
    rd_st(8'h03);
    #(wait_ns);
    rd_st(8'h8C);
    @(negedge clk) wp_n = 1'b0;
    wr_st(8'h00);
    rd_st(8'h8E);
    @(negedge clk) wp_n = 1'b1;
    wr_st(8'h00);
    #(wait_ns);
    rd_st(8'h00);
    cmd(set_write_latch_cmd);
    i_m.shift(15, 16'h0086, rx);
    i_m.stop();
    rd_st(8'h02);
    i_m.set_idle(1'b1);
    cmd(clear_write_latch_cmd);
    rd_st(8'h00);
    i_m.set_idle(1'b0);
    cmd(clear_write_latch_cmd);
    i_m.shift(16, {8'hFF, set_write_latch_cmd}, rx);
    i_m.stop();
    rd_st(8'h00);
    i_m.shift(8, {8'h00, id_page_read_cmd}, rx);
    i_m.shift(16, lock_select_addr, rx);
    chk("lock_access", 16'h0001, {15'h0000, lock_access});
    chk("id_access", 16'h0000, {15'h0000, id_access});
    i_m.stop();
    i_m.shift(8, {8'h00, id_page_read_cmd}, rx);
    i_m.shift(16, 16'h0005, rx);
    chk("id_access", 16'h0001, {15'h0000, id_access});
    chk("lock_access", 16'h0000, {15'h0000, lock_access});
    i_m.stop();
    for (int i = 0; i < 8; i++) begin
      wr_st(t_sr[i]);
      #(wait_ns);
      n = starts;
      if (i < 7) cmd(set_write_latch_cmd);
      i_m.shift(8, {8'h00, array_write_cmd}, rx);
      i_m.shift(16, t_ad[i], rx);
      chk("mem_addr", {4'h0, t_ad[i][11:0]}, {4'h0, mem_addr});
      i_m.shift(8, 16'h00C5, rx);
      chk("mem_wdata", 16'h00C5, {8'h00, mem_wdata});
      i_m.stop();
      #(wait_ns);
      chk("write_start", {15'h0000, t_ok[i]}, 16'(starts - n));
    end
    i_m.shift(8, {8'h00, array_read_cmd}, rx);
    i_m.shift(16, 16'h0010, rx);
    i_m.shift(8, 16'h0000, rx);
    i_m.stop();
    chk("array_read", 16'h00A5, rx);
    cmd(set_write_latch_cmd);
    i_m.shift(16, {array_write_cmd, 8'h01}, rx);
    i_m.shift(16, 16'h003C, rx);
    i_m.stop();
    n = reads;
    i_m.shift(16, {array_read_cmd, 8'h00}, rx);
    i_m.shift(16, 16'h1000, rx);
    i_m.stop();
    chk("read_in_write", 16'h0000, 16'(reads - n));
    chk("wstrobes", 16'h0009, 16'(wstrobes));
    #(wait_ns);
    end_of_test();
  end
endmodule : spi_eeprom_command_protection_tb_top
